//--- logic/usbg_pkg.sv
// shared constants and carrier types for the serial port baud and control block
package usbg_pkg;
  localparam int USBG_CD_W = 16;
  localparam int USBG_FP_W = 3;
  localparam int USBG_CHAR_W = 9;
  localparam int USBG_PREDIV_DEF = 8;
  localparam int USBG_BUF_DEPTH = 2;
  localparam logic [USBG_CD_W-1:0] USBG_CD_STOP = 16'h0000;
  localparam logic [USBG_CD_W-1:0] USBG_CD_BYPASS = 16'h0001;
  localparam logic [3:0] USBG_OVS8_LAST = 4'h7;
  localparam logic [3:0] USBG_OVS16_LAST = 4'hF;
  localparam logic [USBG_FP_W-1:0] USBG_FP_NONE = 3'h0;

  // divider input choice
  typedef enum logic [1:0] {
    USBG_SRC_INT = 2'h0,
    USBG_SRC_PREDIV = 2'h1,
    USBG_SRC_EXT = 2'h2
  } usbg_src_type;

  // pin role choice
  typedef enum logic [1:0] {
    USBG_ROLE_SERIAL = 2'h0,
    USBG_ROLE_SPI_MASTER = 2'h1,
    USBG_ROLE_SPI_SLAVE = 2'h2
  } usbg_role_type;

  // configuration settings, held by software
  typedef struct packed {
    logic [USBG_CD_W-1:0] clock_divider;
    logic [USBG_FP_W-1:0] fractional_part;
    usbg_src_type clock_source_select;
    logic sync_mode;
    logic over_select;
    usbg_role_type spi_role;
  } usbg_cfg_type;

  // one-cycle command strobes
  typedef struct packed {
    logic receiver_enable_cmd;
    logic receiver_disable_cmd;
    logic receiver_reset_cmd;
    logic transmitter_enable_cmd;
    logic transmitter_disable_cmd;
    logic transmitter_reset_cmd;
  } usbg_cmd_type;
endpackage

//--- logic/usbg_buf.sv
// two-entry character buffer acting as transmit holding storage
`timescale 1ns/1ns
module usbg_buf #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0] cnt_q, cnt_d;
  logic push, pop;

  // pointer and count update
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
    if (flush) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end
  end

  assign in_ready = (cnt_q != (PW+1)'(DEPTH)) && !flush;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  // state registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage, written on accepted word
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule

//--- logic/usbg_top.sv
// baud rate generation, enable/disable/reset control and pin roles
`timescale 1ns/1ns
module usbg_top
  import usbg_pkg::*;
#(
  parameter int PREDIV = USBG_PREDIV_DEF,
  parameter int CHAR_W = USBG_CHAR_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // software settings and commands
  input wire usbg_cfg_type cfg,
  input wire usbg_cmd_type cmd,
  // status
  output logic rx_enabled,
  output logic tx_enabled,
  output logic rx_soft_reset,
  output logic tx_soft_reset,
  // timing outputs
  output logic sample_tick,
  output logic bit_tick,
  output logic baud_clk,
  // transmit characters from software
  input wire logic tx_data_valid,
  output logic tx_data_ready,
  input wire logic [CHAR_W-1:0] tx_data,
  // transmit characters toward the shifter
  output logic tx_char_valid,
  input wire logic tx_char_ready,
  output logic [CHAR_W-1:0] tx_char,
  input wire logic tx_shift_busy,
  input wire logic tx_serial,
  // receive framer side
  input wire logic rx_char_busy,
  output logic rx_serial,
  output logic slave_selected,
  // pins
  input wire logic ext_clk_pin,
  input wire logic rxd,
  output logic txd,
  input wire logic cts_low,
  output logic rts_low
);
  logic ext_q, ext_rise, src_tick;
  logic [$clog2(PREDIV)-1:0] pre_q, pre_d;
  logic [USBG_CD_W:0] div_q, div_d, limit;
  logic [USBG_FP_W-1:0] acc_q, acc_d;
  logic [USBG_FP_W:0] acc_sum;
  logic extra_q, extra_d, frac_on;
  logic [3:0] ovs_q, ovs_d, ovs_last;
  logic samp, btick, baud_d, baud_q;
  logic rx_en_q, rx_en_d, rx_pend_q, rx_pend_d;
  logic tx_en_q, tx_en_d, tx_pend_q, tx_pend_d;
  logic txd_d, txd_q, rts_d, rts_q, rxs_d, rxs_q;
  logic buf_in_valid, buf_in_ready, buf_out_valid, tx_idle;
  logic [CHAR_W-1:0] buf_out_data;
  logic [CHAR_W-1:0] tx_char_q;
  logic tx_char_valid_q;

  // source clock selection and pre-division
  always_comb begin
    ext_rise = ext_clk_pin && !ext_q;
    pre_d = (pre_q == ($clog2(PREDIV))'(PREDIV - 1)) ? '0 : pre_q + 1'b1;
    case (cfg.clock_source_select)
      USBG_SRC_INT: src_tick = 1'b1;
      USBG_SRC_PREDIV: src_tick = (pre_q == ($clog2(PREDIV))'(PREDIV - 1));
      USBG_SRC_EXT: src_tick = ext_rise;
      default: src_tick = 1'b0;
    endcase
  end

  // clock divider with optional eighth-step fraction
  always_comb begin
    frac_on = !cfg.sync_mode && (cfg.fractional_part != USBG_FP_NONE);
    limit = {1'b0, cfg.clock_divider} + {{USBG_CD_W{1'b0}}, extra_q && frac_on};
    acc_sum = {1'b0, acc_q} + {1'b0, cfg.fractional_part};
    div_d = div_q;
    acc_d = acc_q;
    extra_d = extra_q;
    samp = 1'b0;
    if (cfg.clock_divider == USBG_CD_STOP) begin
      div_d = '0;
    end else if (src_tick) begin
      if (div_q >= limit - 1'b1) begin // value one bypasses
        samp = 1'b1;
        div_d = '0;
        acc_d = acc_sum[USBG_FP_W-1:0];
        extra_d = acc_sum[USBG_FP_W];
      end else begin
        div_d = div_q + 1'b1;
      end
    end
  end

  // oversampling stage and bit tick
  always_comb begin
    ovs_last = cfg.over_select ? USBG_OVS8_LAST : USBG_OVS16_LAST;
    ovs_d = ovs_q;
    btick = 1'b0;
    if (cfg.sync_mode) begin
      ovs_d = '0;
      btick = (cfg.clock_source_select == USBG_SRC_EXT) ? ext_rise : samp;
    end else if (samp) begin
      btick = (ovs_q == ovs_last);
      ovs_d = (ovs_q >= ovs_last) ? 4'h0 : ovs_q + 1'b1; // drops a count left from x16
    end
    if (cfg.clock_divider == USBG_CD_BYPASS || cfg.clock_source_select != USBG_SRC_INT) begin
      baud_d = cfg.clock_source_select == USBG_SRC_EXT ? ext_clk_pin : samp;
    end else begin
      baud_d = (div_d < {2'b00, cfg.clock_divider[USBG_CD_W-1:1]}); // even split
    end
  end

  // generator registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ext_q <= 1'b0;
      pre_q <= '0;
      div_q <= '0;
      acc_q <= '0;
      extra_q <= 1'b0;
      ovs_q <= '0;
      baud_q <= 1'b0;
    end else begin
      ext_q <= ext_clk_pin;
      pre_q <= pre_d;
      div_q <= div_d;
      acc_q <= acc_d;
      extra_q <= extra_d;
      ovs_q <= ovs_d;
      baud_q <= baud_d;
    end
  end

  assign sample_tick = samp;
  assign bit_tick = btick;
  assign baud_clk = baud_q;

  // receiver and transmitter enable control; reset beats disable, and disable beats enable only while already enabled
  always_comb begin
    tx_idle = !buf_out_valid && !tx_char_valid_q && !tx_shift_busy;
    rx_en_d = rx_en_q;
    rx_pend_d = rx_pend_q;
    if (cmd.receiver_reset_cmd) begin
      rx_en_d = 1'b0;
      rx_pend_d = 1'b0;
    end else if (cmd.receiver_disable_cmd && rx_en_q) begin
      rx_pend_d = 1'b1;
    end else if (cmd.receiver_enable_cmd) begin
      rx_en_d = 1'b1;
      rx_pend_d = 1'b0;
    end
    if (rx_pend_d && !rx_char_busy) begin
      rx_en_d = 1'b0;
      rx_pend_d = 1'b0;
    end
    tx_en_d = tx_en_q;
    tx_pend_d = tx_pend_q;
    if (cmd.transmitter_reset_cmd) begin
      tx_en_d = 1'b0;
      tx_pend_d = 1'b0;
    end else if (cmd.transmitter_disable_cmd && tx_en_q) begin
      tx_pend_d = 1'b1;
    end else if (cmd.transmitter_enable_cmd) begin
      tx_en_d = 1'b1;
      tx_pend_d = 1'b0;
    end
    if (tx_pend_d && tx_idle) begin
      tx_en_d = 1'b0;
      tx_pend_d = 1'b0;
    end
  end

  // control registers, cleared by reset, soft reset or a completed disable
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_en_q <= 1'b0;
      rx_pend_q <= 1'b0;
      tx_en_q <= 1'b0;
      tx_pend_q <= 1'b0;
    end else begin
      rx_en_q <= rx_en_d;
      rx_pend_q <= rx_pend_d;
      tx_en_q <= tx_en_d;
      tx_pend_q <= tx_pend_d;
    end
  end

  assign rx_enabled = rx_en_q;
  assign tx_enabled = tx_en_q;
  assign rx_soft_reset = cmd.receiver_reset_cmd;
  assign tx_soft_reset = cmd.transmitter_reset_cmd;

  // holding storage; refuses new words while off or draining
  assign buf_in_valid = tx_data_valid && tx_en_q && !tx_pend_q;
  assign tx_data_ready = buf_in_ready && tx_en_q && !tx_pend_q;

  usbg_buf #(
    .WIDTH(CHAR_W),
    .DEPTH(USBG_BUF_DEPTH)
  ) u_hold (
    .core_clk(core_clk),
    .reset(reset),
    .flush(cmd.transmitter_reset_cmd),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(tx_data),
    .out_valid(buf_out_valid),
    .out_ready(!tx_char_valid_q || tx_char_ready),
    .out_data(buf_out_data)
  );

  // registered character toward the shifter
  always_ff @(posedge core_clk) begin
    if (reset || cmd.transmitter_reset_cmd) begin
      tx_char_valid_q <= 1'b0;
      tx_char_q <= '0;
    end else if (!tx_char_valid_q || tx_char_ready) begin
      tx_char_valid_q <= buf_out_valid;
      tx_char_q <= buf_out_data;
    end
  end

  assign tx_char_valid = tx_char_valid_q;
  assign tx_char = tx_char_q;

  // pin roles per mode
  always_comb begin
    slave_selected = (cfg.spi_role == USBG_ROLE_SPI_SLAVE) && !cts_low;
    rxs_d = rxd; // rxd is master-in or master-out
    txd_d = tx_serial;
    case (cfg.spi_role)
      USBG_ROLE_SPI_MASTER: rts_d = !tx_en_q;
      USBG_ROLE_SPI_SLAVE: begin
        rts_d = 1'b1;
        txd_d = slave_selected ? tx_serial : 1'b1;
      end
      default: rts_d = !rx_en_q;
    endcase
  end

  // pin registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      txd_q <= 1'b1;
      rts_q <= 1'b1;
      rxs_q <= 1'b1;
    end else begin
      txd_q <= txd_d;
      rts_q <= rts_d;
      rxs_q <= rxs_d;
    end
  end

  assign txd = txd_q;
  assign rts_low = rts_q;
  assign rx_serial = rxs_q;

  // checks
  property p_cd_stop;
    @(posedge core_clk) disable iff (reset)
    cfg.clock_divider == USBG_CD_STOP |-> !sample_tick;
  endproperty
  a_cd_stop: assert property (p_cd_stop) else $error("divider zero yet ticking");
  property p_cd_bypass;
    @(posedge core_clk) disable iff (reset)
    cfg.clock_divider == USBG_CD_BYPASS && !frac_on && src_tick |-> sample_tick;
  endproperty
  a_cd_bypass: assert property (p_cd_bypass) else $error("bypass missed tick");
  property p_sync_bit;
    @(posedge core_clk) disable iff (reset)
    cfg.sync_mode && cfg.clock_source_select != USBG_SRC_EXT |-> bit_tick == sample_tick;
  endproperty
  a_sync_bit: assert property (p_sync_bit) else $error("sync bit tick wrong");
  property p_ovs;
    @(posedge core_clk) disable iff (reset)
    !cfg.sync_mode && bit_tick |-> ovs_q == (cfg.over_select ? USBG_OVS8_LAST : USBG_OVS16_LAST);
  endproperty
  a_ovs: assert property (p_ovs) else $error("oversampling count wrong");
  property p_rx_rst;
    @(posedge core_clk) disable iff (reset)
    cmd.receiver_reset_cmd |=> !rx_enabled;
  endproperty
  a_rx_rst: assert property (p_rx_rst) else $error("receiver not halted");
  property p_tx_en;
    @(posedge core_clk) disable iff (reset)
    cmd.transmitter_enable_cmd && !cmd.transmitter_reset_cmd && !cmd.transmitter_disable_cmd
      |=> tx_enabled;
  endproperty
  a_tx_en: assert property (p_tx_en) else $error("transmitter not enabled");
  property p_rx_wait;
    @(posedge core_clk) disable iff (reset)
    rx_enabled && rx_char_busy && cmd.receiver_disable_cmd && !cmd.receiver_reset_cmd
      |=> rx_enabled;
  endproperty
  a_rx_wait: assert property (p_rx_wait) else $error("receiver cut mid character");
  property p_tx_wait;
    @(posedge core_clk) disable iff (reset)
    tx_enabled && !tx_idle && !cmd.transmitter_reset_cmd |=> tx_enabled;
  endproperty
  a_tx_wait: assert property (p_tx_wait) else $error("transmitter cut while busy");
  property p_no_cmd;
    @(posedge core_clk) disable iff (reset)
    cmd == '0 && !rx_pend_q |=> $stable(rx_enabled);
  endproperty
  a_no_cmd: assert property (p_no_cmd) else $error("receiver changed with no command");
  property p_cs;
    @(posedge core_clk) disable iff (reset)
    cfg.spi_role == USBG_ROLE_SPI_MASTER |=> rts_low == !$past(tx_en_q);
  endproperty
  a_cs: assert property (p_cs) else $error("chip select wrong");
  property p_slave_tx;
    @(posedge core_clk) disable iff (reset)
    cfg.spi_role == USBG_ROLE_SPI_SLAVE && cts_low |=> txd;
  endproperty
  a_slave_tx: assert property (p_slave_tx) else $error("unselected slave drove data");
endmodule

//--- tb/usbg_peer.sv
// far-side model: character shifter and external clock source
`timescale 1ns/1ns
module usbg_peer #(
  parameter int CHAR_W = 9,
  parameter int EXT_HALF = 5
) (
  // clock
  input wire logic core_clk,
  // bench controls
  input wire logic stall,
  input wire logic ext_run,
  // character handshake
  input wire logic tx_char_valid,
  input wire logic [CHAR_W-1:0] tx_char,
  output logic tx_char_ready,
  output logic tx_shift_busy,
  output logic tx_serial,
  // pin clock
  output logic ext_clk_pin
);
  logic [CHAR_W-1:0] got [$];
  logic [CHAR_W-1:0] sh_q;
  int bits_q;
  int ph_q;
  initial begin
    tx_shift_busy = 1'b0;
    tx_serial = 1'b1;
    ext_clk_pin = 1'b0;
    bits_q = 0;
    ph_q = 0;
  end
  // ready only when idle and not stalled
  assign tx_char_ready = !stall && !tx_shift_busy;
  // take a character, shift it out lsb first, idle high
  always @(posedge core_clk) begin
    if (tx_char_valid && tx_char_ready) begin
      got.push_back(tx_char);
      sh_q <= tx_char;
      bits_q <= CHAR_W;
      tx_shift_busy <= 1'b1;
    end else if (bits_q > 0) begin
      tx_serial <= sh_q[0];
      sh_q <= sh_q >> 1;
      bits_q <= bits_q - 1;
      tx_shift_busy <= (bits_q > 1);
    end else begin
      tx_serial <= 1'b1;
    end
  end
  // pin clock, still when not running, phases well above core phases
  always @(posedge core_clk) begin
    if (!ext_run) begin
      ph_q <= 0;
      ext_clk_pin <= 1'b0;
    end else if (ph_q == EXT_HALF - 1) begin
      ph_q <= 0;
      ext_clk_pin <= !ext_clk_pin;
    end else begin
      ph_q <= ph_q + 1;
    end
  end
endmodule

//--- tb/usbg_top_bench.sv
// self-checking bench for the baud and control block
`timescale 1ns/1ns
module usbg_top_bench
  import usbg_pkg::*;
;
  localparam int PDIV = 4;
  localparam int EXH = 5;
  logic core_clk, reset, tx_data_valid, rx_char_busy, rxd, cts_low, stall, ext_run;
  usbg_cfg_type cfg;
  usbg_cmd_type cmd;
  logic [USBG_CHAR_W-1:0] tx_data, tx_char;
  logic rx_enabled, tx_enabled, rx_soft_reset, tx_soft_reset, sample_tick, bit_tick;
  logic tx_data_ready, tx_char_valid, tx_char_ready, tx_shift_busy, tx_serial;
  logic rx_serial, slave_selected, ext_clk_pin, txd, rts_low, baud_clk;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  usbg_top #(.PREDIV(PDIV), .CHAR_W(USBG_CHAR_W)) dut (
    .core_clk(core_clk), .reset(reset), .cfg(cfg), .cmd(cmd),
    .rx_enabled(rx_enabled), .tx_enabled(tx_enabled),
    .rx_soft_reset(rx_soft_reset), .tx_soft_reset(tx_soft_reset),
    .sample_tick(sample_tick), .bit_tick(bit_tick), .baud_clk(baud_clk),
    .tx_data_valid(tx_data_valid), .tx_data_ready(tx_data_ready), .tx_data(tx_data),
    .tx_char_valid(tx_char_valid), .tx_char_ready(tx_char_ready), .tx_char(tx_char),
    .tx_shift_busy(tx_shift_busy), .tx_serial(tx_serial), .rx_char_busy(rx_char_busy),
    .rx_serial(rx_serial), .slave_selected(slave_selected), .ext_clk_pin(ext_clk_pin),
    .rxd(rxd), .txd(txd), .cts_low(cts_low), .rts_low(rts_low)
  );
  usbg_peer #(.CHAR_W(USBG_CHAR_W), .EXT_HALF(EXH)) u_peer (
    .core_clk(core_clk), .stall(stall), .ext_run(ext_run), .tx_char_valid(tx_char_valid),
    .tx_char(tx_char), .tx_char_ready(tx_char_ready), .tx_shift_busy(tx_shift_busy),
    .tx_serial(tx_serial), .ext_clk_pin(ext_clk_pin)
  );

  // clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // one-cycle command strobe
  task automatic pulse(input usbg_cmd_type c);
    @(posedge core_clk);
    cmd <= c;
    @(posedge core_clk);
    cmd <= '0;
  endtask

  // cycles spanned by reps tick periods, 0 when ticks never come
  task automatic gap(input logic bt, input int reps, output int g);
    int n;
    int t;
    n = 0;
    g = 0;
    t = 0;
    while (n <= reps && t < 200) begin
      @(negedge core_clk);
      t++;
      if (n > 0) g++;
      if ((bt ? bit_tick : sample_tick) === 1'b1) n++;
    end
    if (n <= reps) g = 0;
  endtask

  task automatic rate(input logic [15:0] cd, input logic [2:0] fp, input usbg_src_type src,
      input logic sy, input logic ov, input logic bt, input int reps, input int e);
    int g;
    @(posedge core_clk);
    cfg.clock_divider <= cd;
    cfg.fractional_part <= fp;
    cfg.clock_source_select <= src;
    cfg.sync_mode <= sy;
    cfg.over_select <= ov;
    gap(bt, 1, g);
    gap(bt, reps, g);
    check(g, e);
  endtask

  // idle state after reset, zero and joint enables
  task automatic t_enable();
    @(negedge core_clk);
    check({rx_enabled, tx_enabled, txd, rts_low, tx_char_valid}, 5'h06);
    pulse(6'h00);
    @(negedge core_clk);
    check({rx_enabled, tx_enabled}, 2'h0);
    pulse(6'h24);
    @(negedge core_clk);
    check({rx_enabled, tx_enabled}, 2'h3);
    @(negedge core_clk);
    check(rts_low, 1'b0);
    pulse(6'h00);
    @(negedge core_clk);
    check({rx_enabled, tx_enabled}, 2'h3);
  endtask

  // soft reset wins over enable, flushes held word, keeps settings
  task automatic t_srst();
    int g;
    u_peer.got.delete();
    @(posedge core_clk);
    stall <= 1'b1;
    tx_data_valid <= 1'b1;
    tx_data <= 9'h155;
    @(posedge core_clk);
    tx_data_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    cmd <= 6'h2D;
    @(negedge core_clk);
    check({rx_soft_reset, tx_soft_reset}, 2'h3);
    @(posedge core_clk);
    cmd <= '0;
    stall <= 1'b0;
    repeat (3) @(negedge core_clk);
    check({rx_enabled, tx_enabled, tx_char_valid}, 3'h0);
    check(u_peer.got.size(), 0);
    gap(1'b0, 1, g);
    check(g, 5);
  endtask

  // receiver disable held off by a character in progress
  task automatic t_rx();
    @(posedge core_clk);
    rx_char_busy <= 1'b1;
    pulse(6'h20);
    pulse(6'h10);
    repeat (4) @(negedge core_clk);
    check(rx_enabled, 1'b1);
    @(posedge core_clk);
    rx_char_busy <= 1'b0;
    repeat (3) @(negedge core_clk);
    check(rx_enabled, 1'b0);
    pulse(6'h10);
    @(negedge core_clk);
    check(rx_enabled, 1'b0);
  endtask

  // fill against a stalled shifter, disable, then drain in order
  task automatic t_tx();
    int k;
    logic prev;
    u_peer.got.delete();
    @(posedge core_clk);
    stall <= 1'b1;
    cts_low <= 1'b0;
    cfg.spi_role <= USBG_ROLE_SPI_SLAVE;
    pulse(6'h04);
    tx_data_valid <= 1'b1;
    tx_data <= 9'h1A0;
    k = 0;
    repeat (6) begin
      @(posedge core_clk);
      if (tx_data_ready === 1'b1) begin
        k++;
        tx_data <= tx_data + 9'h001;
      end
    end
    tx_data_valid <= 1'b0;
    @(negedge core_clk);
    check(k, USBG_BUF_DEPTH + 1);
    pulse(6'h02);
    repeat (5) @(negedge core_clk);
    check({tx_enabled, tx_data_ready}, 2'h2);
    @(posedge core_clk);
    stall <= 1'b0;
    prev = tx_serial;
    repeat (120) begin
      @(negedge core_clk);
      check(txd, prev);
      prev = tx_serial;
    end
    check(tx_enabled, 1'b0);
    check(u_peer.got.size(), k);
    foreach (u_peer.got[i]) check(u_peer.got[i], 9'h1A0 + i);
  endtask

  // pin roles in SPI master and slave operation
  task automatic t_roles();
    @(posedge core_clk);
    cfg.spi_role <= USBG_ROLE_SPI_MASTER;
    rxd <= 1'b0;
    repeat (2) @(negedge core_clk);
    check({rts_low, rx_serial}, 2'h2);
    pulse(6'h04);
    repeat (2) @(negedge core_clk);
    check(rts_low, 1'b0);
    @(posedge core_clk);
    cfg.spi_role <= USBG_ROLE_SPI_SLAVE;
    cts_low <= 1'b1;
    rxd <= 1'b1;
    repeat (2) @(negedge core_clk);
    check({slave_selected, txd, rx_serial}, 3'h3);
    @(posedge core_clk);
    cts_low <= 1'b0;
    @(negedge core_clk);
    check(slave_selected, 1'b1);
  endtask

  // even split of the internal-source bit clock, then port off before the run stops
  task automatic t_duty();
    int h;
    @(posedge core_clk);
    cfg.clock_divider <= 16'h0004;
    cfg.clock_source_select <= USBG_SRC_INT;
    cfg.sync_mode <= 1'b1;
    h = 0;
    repeat (4) @(negedge core_clk);
    repeat (40) begin
      @(negedge core_clk);
      if (baud_clk === 1'b1) h++;
    end
    check(h, 20);
    pulse(6'h12);
    repeat (2) @(negedge core_clk);
    check({rx_enabled, tx_enabled}, 2'h0);
  endtask

  // stimulus
  initial begin
    reset <= 1'b1;
    cfg <= '{16'h0005, 3'h0, USBG_SRC_INT, 1'b0, 1'b1, USBG_ROLE_SERIAL};
    cmd <= '0;
    tx_data_valid <= 1'b0;
    tx_data <= '0;
    rx_char_busy <= 1'b0;
    rxd <= 1'b1;
    cts_low <= 1'b1;
    stall <= 1'b0;
    ext_run <= 1'b0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    t_enable();
    t_srst();
    t_rx();
    t_tx();
    t_roles();
    ext_run <= 1'b1;
    rate(16'h0000, 3'h0, USBG_SRC_INT, 1'b0, 1'b1, 1'b0, 1, 0);
    rate(16'h0001, 3'h0, USBG_SRC_INT, 1'b0, 1'b1, 1'b0, 1, 1);
    rate(16'h0001, 3'h0, USBG_SRC_INT, 1'b0, 1'b1, 1'b1, 1, 8);
    rate(16'h0003, 3'h0, USBG_SRC_INT, 1'b0, 1'b0, 1'b1, 1, 48);
    rate(16'h0005, 3'h0, USBG_SRC_INT, 1'b0, 1'b1, 1'b0, 1, 5);
    rate(16'h0002, 3'h4, USBG_SRC_INT, 1'b0, 1'b1, 1'b0, 2, 5);
    rate(16'h0003, 3'h0, USBG_SRC_INT, 1'b1, 1'b0, 1'b1, 1, 3);
    rate(16'h0002, 3'h0, USBG_SRC_PREDIV, 1'b1, 1'b0, 1'b1, 1, 2 * PDIV);
    rate(16'h0007, 3'h0, USBG_SRC_EXT, 1'b1, 1'b0, 1'b1, 1, 2 * EXH);
    rate(16'h0002, 3'h0, USBG_SRC_EXT, 1'b0, 1'b1, 1'b0, 1, 4 * EXH);
    t_duty();
    results();
  end
endmodule
